// ---- common/pdv_pkg.sv ----
package pdv_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VALUE = 8'h04;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_CHARS = 8'h18;
  localparam logic [7:0] ADDR_CHAR_SEL = 8'h1c;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_SIX_DIGIT_BIT = 1;

  // ----------------------------------------------------------------
  // display codes and ranges
  // ----------------------------------------------------------------
  localparam logic [2:0] SHOW_IDENT = 3'h0;
  localparam logic [2:0] SHOW_DASHES = 3'h1;
  localparam logic [2:0] SHOW_VALUE = 3'h2;
  localparam logic [2:0] SHOW_OVER = 3'h3;
  localparam logic [2:0] SHOW_UNDER = 3'h4;
  localparam logic [2:0] SHOW_MENU = 3'h5;
  localparam logic signed [31:0] MIN4 = -32'sd999;
  localparam logic signed [31:0] MAX4 = 32'sd9999;
  localparam logic signed [31:0] MIN6 = -32'sd99999;
  localparam logic signed [31:0] MAX6 = 32'sd999999;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int IDENT_MS = 1000;
  localparam int IDENT_CYCLES = (CLK_HZ / 1000) * IDENT_MS;
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_03e8;
  localparam logic [31:0] REVISION = 32'h0000_0001;  // arbitrary value

  // ----------------------------------------------------------------
  // interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_RANGE = 1;
  localparam int IRQ_MENU = 2;
  localparam int IRQ_WIDTH = 3;

  typedef enum logic [2:0] {
    ST_IDENT = 3'b000,
    ST_DISPLAY = 3'b001,
    ST_MENU = 3'b010,
    ST_EDIT = 3'b011,
    ST_CONFIRM = 3'b100
  } pdv_state_t;

endpackage : pdv_pkg

// ---- hdl/pdv_control.sv ----
// Behaviour
// - after reset show identity and version, then enter displaying mode
// - on entering display, show dashes until first value update
// - stored role bit selects master or follower operation
// - follower value and attributes come only from externally written regs
// - master role takes value and decimal point from polled follower
// - value above range shows over-range message
// - value below range shows under-range message
// - range -999..9999 for four digits, -99999..999999 for six
// - configuration changes never stop the display logic
// - follower shows dashes until first write of shown value
// - follower blinks value when no write within update timeout
// - next valid value write stops the blinking
// - follower may show user characters at selected digit positions
// - follower menu offered only in follower role
// - main menu entered after escape key held two seconds
// - escape leaves level upward and discards unconfirmed edit
// - enter starts edit, opens sub-menu or confirms edit; code has no sub-menu state, enter in menu always starts edit
// - up and down step items, change edit value or display mode
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module pdv_control #(
  parameter int HOLD_COUNT = pdv_pkg::HOLD_CYCLES,
  parameter int TICK_COUNT = pdv_pkg::TICK_CYCLES,
  parameter int IDENT_COUNT = pdv_pkg::IDENT_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // remote follower answer in master role
  input wire logic poll_valid,
  input wire logic [31:0] poll_value,
  input wire logic [2:0] poll_point,
  // keys, one-cycle pulses except esc level
  input wire logic key_esc,
  input wire logic key_enter,
  input wire logic key_up,
  input wire logic key_down,
  // display
  output logic [2:0] show_code,
  output logic [31:0] show_value,
  output logic [2:0] show_point,
  output logic show_blink,
  output logic [5:0] user_char_sel,
  output logic [31:0] user_chars,
  output logic follower_menu_visible,
  output logic [3:0] menu_item,
  output logic [1:0] display_mode,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic ph_wr_reg, ph_rd_reg;
  logic [7:0] ph_addr_reg;
  logic take;
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg <= 1'b0;
      ph_rd_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else begin
      ph_wr_reg <= take && hwrite;
      ph_rd_reg <= take && !hwrite;
      ph_addr_reg <= haddr;
    end
  end

  logic wr_ctrl, wr_value, wr_timeout, wr_mask, wr_chars, wr_sel;
  logic rd_irq_stat;
  assign wr_ctrl = ph_wr_reg && ph_addr_reg == pdv_pkg::ADDR_CTRL;
  assign wr_value = ph_wr_reg && ph_addr_reg == pdv_pkg::ADDR_VALUE;
  assign wr_timeout = ph_wr_reg && ph_addr_reg == pdv_pkg::ADDR_TIMEOUT;
  assign wr_mask = ph_wr_reg && ph_addr_reg == pdv_pkg::ADDR_IRQ_MASK;
  assign wr_chars = ph_wr_reg && ph_addr_reg == pdv_pkg::ADDR_CHARS;
  assign wr_sel = ph_wr_reg && ph_addr_reg == pdv_pkg::ADDR_CHAR_SEL;
  assign rd_irq_stat = ph_rd_reg && ph_addr_reg == pdv_pkg::ADDR_IRQ_STAT;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic [31:0] timeout_reg;
  logic [31:0] chars_reg;
  logic [5:0] sel_reg;
  logic [31:0] value_reg;
  logic [2:0] point_reg;

  // config writes land any time, display keeps running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= 2'b00;
      timeout_reg <= pdv_pkg::TIMEOUT_RESET;
      chars_reg <= 32'h0000_0000;
      sel_reg <= 6'h00;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= hwdata[1:0];
      if (wr_timeout)
        timeout_reg <= hwdata;
      if (wr_chars)
        chars_reg <= hwdata;
      if (wr_sel)
        sel_reg <= hwdata[5:0];
    end
  end

  logic is_master;
  assign is_master = ctrl_reg[pdv_pkg::CTRL_MASTER_BIT];

  // ----------------------------------------------------------------
  // shown value source
  // ----------------------------------------------------------------
  logic update;
  assign update = is_master ? poll_valid : wr_value;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_reg <= 32'h0000_0000;
      point_reg <= 3'h0;
    end else if (is_master && poll_valid) begin
      value_reg <= poll_value;
      point_reg <= poll_point;
    end else if (!is_master && wr_value) begin
      value_reg <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // update timeout, millisecond ticks
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  logic tick;
  assign tick = tick_cnt_reg == 32'(TICK_COUNT - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
  end

  logic seen_reg, blink_reg;
  logic [31:0] age_reg;
  logic blink_rise;
  assign blink_rise = seen_reg && !blink_reg && !update && tick
    && age_reg + 32'h0000_0001 >= timeout_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_reg <= 1'b0;
      age_reg <= 32'h0000_0000;
      blink_reg <= 1'b0;
    end else if (update) begin
      seen_reg <= 1'b1;
      age_reg <= 32'h0000_0000;
      blink_reg <= 1'b0;
    end else if (seen_reg && tick) begin
      if (!blink_reg)
        age_reg <= age_reg + 32'h0000_0001;
      if (blink_rise)
        blink_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // range check
  // ----------------------------------------------------------------
  logic six;
  logic signed [31:0] lo, hi, sval;
  logic over, under;
  assign six = ctrl_reg[pdv_pkg::CTRL_SIX_DIGIT_BIT];
  assign lo = six ? pdv_pkg::MIN6 : pdv_pkg::MIN4;
  assign hi = six ? pdv_pkg::MAX6 : pdv_pkg::MAX4;
  assign sval = value_reg;
  assign over = sval > hi;
  assign under = sval < lo;

  // ----------------------------------------------------------------
  // menu state machine
  // ----------------------------------------------------------------
  pdv_pkg::pdv_state_t state_reg;
  logic [31:0] ident_cnt_reg, hold_cnt_reg;
  logic [3:0] item_reg;
  logic [31:0] edit_reg;
  logic [1:0] mode_reg;
  logic hold_done;
  assign hold_done = hold_cnt_reg == 32'(HOLD_COUNT - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hold_cnt_reg <= 32'h0000_0000;
    else if (!key_esc || state_reg != pdv_pkg::ST_DISPLAY)
      hold_cnt_reg <= 32'h0000_0000;
    else if (!hold_done)
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
  end

  logic esc_prev_reg, esc_press;
  assign esc_press = key_esc && !esc_prev_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      esc_prev_reg <= 1'b0;
    else
      esc_prev_reg <= key_esc;
  end

  logic menu_enter;
  assign menu_enter = state_reg == pdv_pkg::ST_DISPLAY && hold_done
    && key_esc;
  // item 0 is the follower menu; skipped in master role
  logic [3:0] item_up, item_dn;
  assign item_up = (item_reg == 4'hf || (is_master && item_reg == 4'hf))
    ? (is_master ? 4'h1 : 4'h0) : item_reg + 4'h1;
  assign item_dn = (item_reg == (is_master ? 4'h1 : 4'h0))
    ? 4'hf : item_reg - 4'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= pdv_pkg::ST_IDENT;
      ident_cnt_reg <= 32'h0000_0000;
      item_reg <= 4'h0;
      edit_reg <= 32'h0000_0000;
      mode_reg <= 2'b00;
    end else begin
      case (state_reg)
        pdv_pkg::ST_IDENT: begin
          ident_cnt_reg <= ident_cnt_reg + 32'h0000_0001;
          if (ident_cnt_reg == 32'(IDENT_COUNT - 1))
            state_reg <= pdv_pkg::ST_DISPLAY;
        end
        pdv_pkg::ST_DISPLAY: begin
          if (menu_enter) begin
            state_reg <= pdv_pkg::ST_MENU;
            item_reg <= is_master ? 4'h1 : 4'h0;
          end else if (key_up)
            mode_reg <= mode_reg + 2'b01;
          else if (key_down)
            mode_reg <= mode_reg - 2'b01;
        end
        pdv_pkg::ST_MENU: begin
          if (is_master && item_reg == 4'h0)
            item_reg <= 4'h1;
          if (esc_press)
            state_reg <= pdv_pkg::ST_DISPLAY;
          else if (key_enter) begin
            state_reg <= pdv_pkg::ST_EDIT;
            edit_reg <= 32'h0000_0000;
          end else if (key_up)
            item_reg <= item_up;
          else if (key_down)
            item_reg <= item_dn;
        end
        pdv_pkg::ST_EDIT: begin
          if (esc_press)
            state_reg <= pdv_pkg::ST_MENU;
          else if (key_enter)
            state_reg <= pdv_pkg::ST_CONFIRM;
          else if (key_up)
            edit_reg <= edit_reg + 32'h0000_0001;
          else if (key_down)
            edit_reg <= edit_reg - 32'h0000_0001;
        end
        pdv_pkg::ST_CONFIRM: begin
          if (esc_press) begin
            state_reg <= pdv_pkg::ST_MENU;
            edit_reg <= 32'h0000_0000;
          end else if (key_enter)
            state_reg <= pdv_pkg::ST_MENU;
        end
        default: state_reg <= pdv_pkg::ST_IDENT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // display outputs
  // ----------------------------------------------------------------
  logic [2:0] code_next;
  always_comb begin
    if (state_reg == pdv_pkg::ST_IDENT)
      code_next = pdv_pkg::SHOW_IDENT;
    else if (state_reg != pdv_pkg::ST_DISPLAY)
      code_next = pdv_pkg::SHOW_MENU;
    else if (!seen_reg)
      code_next = pdv_pkg::SHOW_DASHES;
    else if (over)
      code_next = pdv_pkg::SHOW_OVER;
    else if (under)
      code_next = pdv_pkg::SHOW_UNDER;
    else
      code_next = pdv_pkg::SHOW_VALUE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      show_code <= pdv_pkg::SHOW_IDENT;
      show_value <= 32'h0000_0000;
      show_point <= 3'h0;
      show_blink <= 1'b0;
      user_char_sel <= 6'h00;
      user_chars <= 32'h0000_0000;
      follower_menu_visible <= 1'b0;
      menu_item <= 4'h0;
      display_mode <= 2'b00;
    end else begin
      show_code <= code_next;
      show_value <= state_reg == pdv_pkg::ST_DISPLAY ? value_reg : edit_reg;
      show_point <= point_reg;
      show_blink <= blink_reg;
      user_char_sel <= is_master ? 6'h00 : sel_reg;
      user_chars <= chars_reg;
      follower_menu_visible <= !is_master && state_reg != pdv_pkg::ST_IDENT
        && state_reg != pdv_pkg::ST_DISPLAY;
      menu_item <= item_reg;
      display_mode <= mode_reg;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [2:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic range_prev_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      range_prev_reg <= 1'b0;
    else
      range_prev_reg <= seen_reg && (over || under);
  end
  assign irq_set = {menu_enter, seen_reg && (over || under) && !range_prev_reg,
    blink_rise};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= 3'b000;
      irq_mask_reg <= 3'b000;
    end else begin
      irq_stat_reg <= (rd_irq_stat ? 3'b000 : irq_stat_reg) | irq_set;
      if (wr_mask)
        irq_mask_reg <= hwdata[2:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ph_rd_reg) begin
      case (ph_addr_reg)
        pdv_pkg::ADDR_CTRL: hrdata = {30'h0, ctrl_reg};
        pdv_pkg::ADDR_VALUE: hrdata = value_reg;
        pdv_pkg::ADDR_TIMEOUT: hrdata = timeout_reg;
        pdv_pkg::ADDR_STATUS:
          hrdata = {20'h0, item_reg, 1'b0, state_reg, blink_reg, seen_reg,
            over, under};
        pdv_pkg::ADDR_IRQ_STAT: hrdata = {29'h0, irq_stat_reg};
        pdv_pkg::ADDR_IRQ_MASK: hrdata = {29'h0, irq_mask_reg};
        pdv_pkg::ADDR_CHARS: hrdata = chars_reg;
        pdv_pkg::ADDR_CHAR_SEL: hrdata = {26'h0, sel_reg};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : pdv_control
`default_nettype wire

// ---- test/pdv_control_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module pdv_control_sva #(
  parameter int HOLD_COUNT = 8
) (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // poll and keys
  input wire logic poll_valid,
  input wire logic [31:0] poll_value,
  input wire logic key_esc,
  // display
  input wire logic [2:0] show_code,
  input wire logic show_blink,
  input wire logic follower_menu_visible
);
  logic [7:0] dp_addr;
  logic dp_wr;
  logic seen;
  logic role;
  logic signed [31:0] val;
  int esc_cnt;
  wire logic val_wr = dp_wr && dp_addr == pdv_pkg::ADDR_VALUE && !role;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_wr <= hsel && htrans[1] && hwrite;
      dp_addr <= haddr;
    end
  end

  // shadow of role, first update and shown value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen <= 1'b0;
      role <= 1'b0;
      val <= 32'h0000_0000;
    end else begin
      if (val_wr || (poll_valid && role)) begin
        seen <= 1'b1;
        val <= val_wr ? hwdata : poll_value;
      end
      if (dp_wr && dp_addr == pdv_pkg::ADDR_CTRL) begin
        role <= hwdata[pdv_pkg::CTRL_MASTER_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      esc_cnt <= 0;
    end else begin
      esc_cnt <= key_esc ? esc_cnt + 1 : 0;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ident_first_a: assert property (
    $rose(hresetn) |-> show_code == pdv_pkg::SHOW_IDENT [*3])
    else $error("identity not shown after reset");
  dash_hold_a: assert property (
    !seen && show_code != pdv_pkg::SHOW_IDENT
    && show_code != pdv_pkg::SHOW_MENU |-> show_code == pdv_pkg::SHOW_DASHES)
    else $error("value shown before first update");
  blink_seen_a: assert property (show_blink |-> seen)
    else $error("blink before first update");
  blink_stop_a: assert property (val_wr |-> ##[1:2] !show_blink)
    else $error("blink kept after value write");
  over_range_a: assert property (
    show_code == pdv_pkg::SHOW_OVER |-> $past(val) > pdv_pkg::MAX4)
    else $error("over-range shown for small value");
  under_range_a: assert property (
    show_code == pdv_pkg::SHOW_UNDER |-> $past(val) < pdv_pkg::MIN4)
    else $error("under-range shown for large value");
  value_range_a: assert property (
    show_code == pdv_pkg::SHOW_VALUE |->
    $past(val) <= pdv_pkg::MAX6 && $past(val) >= pdv_pkg::MIN6)
    else $error("number shown outside range");
  menu_hold_a: assert property (
    $rose(show_code == pdv_pkg::SHOW_MENU) |-> $past(esc_cnt) >= HOLD_COUNT)
    else $error("menu entered without long hold");
  menu_vis_a: assert property (follower_menu_visible |-> !$past(role))
    else $error("follower menu shown in master role");
endmodule : pdv_control_sva
bind pdv_control pdv_control_sva #(.HOLD_COUNT(HOLD_COUNT)) i_pdv_control_sva (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .poll_valid, .poll_value, .key_esc, .show_code, .show_blink,
  .follower_menu_visible);
`default_nettype wire

// ---- test/pdv_poll_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pdv_poll_model (
  // control from bench
  input wire logic hclk,
  input wire logic req,
  input wire logic [3:0] dly,
  input wire logic [31:0] val,
  input wire logic [2:0] pnt,
  // answer
  output logic poll_valid,
  output logic [31:0] poll_value,
  output logic [2:0] poll_point
);
  int cnt;
  initial begin
    cnt = 0;
    poll_valid = 1'b0;
    poll_value = 32'h0000_0000;
    poll_point = 3'h0;
  end
  // answers after dly cycles; data lines toggle when not valid
  always @(posedge hclk) begin
    poll_valid <= 1'b0;
    poll_value <= ~poll_value;
    poll_point <= ~poll_point;
    if (req) begin
      cnt <= dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        poll_valid <= 1'b1;
        poll_value <= val;
        poll_point <= pnt;
      end
    end
  end
endmodule : pdv_poll_model
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic hclk, hresetn, hsel, hwrite, key_esc, key_enter, key_up, key_down;
  logic req;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, pnt;
  logic [3:0] dly;
  logic [31:0] hwdata, pval, rd;
  wire logic [31:0] hrdata, poll_value, show_value, user_chars;
  wire logic hreadyout, hresp, poll_valid, show_blink;
  wire logic follower_menu_visible, irq;
  wire logic [2:0] poll_point, show_code, show_point;
  wire logic [5:0] user_char_sel;
  wire logic [3:0] menu_item;
  wire logic [1:0] display_mode;
  wire logic hready = hreadyout;
  int failures, n_checks;
  logic [31:0] rv [8] = '{32'd9999, 32'd10000, -32'd999, -32'd1000,
    32'd999999, 32'd1000000, -32'd99999, -32'd100000};

  pdv_control #(.HOLD_COUNT(8), .TICK_COUNT(4), .IDENT_COUNT(5)) i_pdv_control (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .poll_valid, .poll_value,
    .poll_point, .key_esc, .key_enter, .key_up, .key_down, .show_code,
    .show_value, .show_point, .show_blink, .user_char_sel, .user_chars,
    .follower_menu_visible, .menu_item, .display_mode, .irq);
  pdv_poll_model i_pdv_poll_model (.hclk, .req, .dly, .val(pval), .pnt,
    .poll_valid, .poll_value, .poll_point);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    if (w) hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      failures++;
      stop_test;
    end
  endtask : ahb
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    ahb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rdchk
  task press(input logic [2:0] k);
    {key_enter, key_up, key_down} <= k;
    tick(1);
    {key_enter, key_up, key_down} <= 3'h0;
    tick(3);
  endtask : press
  task esc(input int n);
    key_esc <= 1'b1;
    tick(n);
    key_esc <= 1'b0;
    tick(3);
  endtask : esc

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_ident;
    tick(1);
    chk(show_code, pdv_pkg::SHOW_IDENT, "ident");
    tick(8);
    chk(show_code, pdv_pkg::SHOW_DASHES, "dashes");
    rdchk(pdv_pkg::ADDR_TIMEOUT, pdv_pkg::TIMEOUT_RESET, "timeout rst");
    wr(8'h20, 32'h5);
    rdchk(8'h20, 32'h0, "unmapped");
    rdchk(pdv_pkg::ADDR_IRQ_MASK, 32'h0, "mask rst");
    chk(hresp, 32'h0, "okay resp");
    $display("test ident done");
  endtask : t_ident
  task t_master;
    wr(pdv_pkg::ADDR_CTRL, 32'h1);
    wr(pdv_pkg::ADDR_VALUE, 32'h7);
    wr(pdv_pkg::ADDR_CHAR_SEL, 32'h3f);
    tick(2);
    chk(show_code, pdv_pkg::SHOW_DASHES, "write in master");
    chk(user_char_sel, 32'h0, "chars in master");
    for (int i = 0; i < 2; i++) begin
      pval <= 32'd100 + i;
      pnt <= 3'h2 + i;
      dly <= i ? 4'h1 : 4'h9;
      req <= 1'b1;
      tick(1);
      req <= 1'b0;
      tick(14);
      chk(show_code, pdv_pkg::SHOW_VALUE, "poll code");
      chk(show_value, 32'd100 + i, "poll value");
      chk(show_point, 3'h2 + i, "poll point");
    end
    wr(pdv_pkg::ADDR_CTRL, 32'h0);
    wr(pdv_pkg::ADDR_CHARS, 32'h1234_5678);
    tick(2);
    chk(user_char_sel, 32'h3f, "char sel");
    chk(user_chars, 32'h1234_5678, "chars");
    $display("test master done");
  endtask : t_master
  task t_range;
    wr(pdv_pkg::ADDR_IRQ_MASK, 32'h2);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr(pdv_pkg::ADDR_CTRL, 32'h2);
      wr(pdv_pkg::ADDR_VALUE, rv[i]);
      tick(2);
      chk(show_code, i % 2 == 0 ? pdv_pkg::SHOW_VALUE : i % 4 == 1 ?
        pdv_pkg::SHOW_OVER : pdv_pkg::SHOW_UNDER, "range");
      if (i % 2) begin
        chk(irq, 32'h1, "range irq");
        rdchk(pdv_pkg::ADDR_IRQ_STAT, 32'h2, "range stat");
        tick(1);
        chk(irq, 32'h0, "irq cleared");
      end
    end
    wr(pdv_pkg::ADDR_IRQ_MASK, 32'h0);
    wr(pdv_pkg::ADDR_VALUE, 32'd0);
    wr(pdv_pkg::ADDR_VALUE, 32'd2000000);
    tick(2);
    chk(irq, 32'h0, "masked irq");
    rdchk(pdv_pkg::ADDR_IRQ_STAT, 32'h2, "masked stat");
    wr(pdv_pkg::ADDR_CTRL, 32'h0);
    $display("test range done");
  endtask : t_range
  task t_blink;
    int n;
    wr(pdv_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(pdv_pkg::ADDR_TIMEOUT, 32'h3);
    wr(pdv_pkg::ADDR_VALUE, 32'h5);
    tick(6);
    wr(pdv_pkg::ADDR_VALUE, 32'h6);
    n = 0;
    while (show_blink !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(n >= 8 && n <= 20, 32'h1, "blink delay");
    chk(irq, 32'h1, "blink irq");
    rdchk(pdv_pkg::ADDR_IRQ_STAT, 32'h1, "blink stat");
    wr(pdv_pkg::ADDR_TIMEOUT, pdv_pkg::TIMEOUT_RESET);
    wr(pdv_pkg::ADDR_VALUE, 32'h7);
    tick(2);
    chk(show_blink, 32'h0, "blink stop");
    $display("test blink done");
  endtask : t_blink
  task t_menu;
    wr(pdv_pkg::ADDR_IRQ_MASK, 32'h4);
    press(3'b010);
    chk(display_mode, 32'h1, "display mode");
    esc(5);
    chk(show_code, pdv_pkg::SHOW_VALUE, "short hold");
    esc(10);
    chk(show_code, pdv_pkg::SHOW_MENU, "menu");
    chk(follower_menu_visible, 32'h1, "follower menu");
    chk(menu_item, 32'h0, "first item");
    rdchk(pdv_pkg::ADDR_IRQ_STAT, 32'h4, "menu stat");
    press(3'b010);
    chk(menu_item, 32'h1, "item step");
    press(3'b100);
    ahb(1'b0, pdv_pkg::ADDR_STATUS, 32'h0);
    chk(rd[6:4], pdv_pkg::ST_EDIT, "edit");
    wr(pdv_pkg::ADDR_VALUE, 32'd42);
    esc(1);
    ahb(1'b0, pdv_pkg::ADDR_STATUS, 32'h0);
    chk(rd[6:4], pdv_pkg::ST_MENU, "esc edit");
    esc(1);
    chk(show_code, pdv_pkg::SHOW_VALUE, "esc menu");
    chk(show_value, 32'd42, "value in menu");
    wr(pdv_pkg::ADDR_CTRL, 32'h1);
    esc(10);
    chk(follower_menu_visible, 32'h0, "hidden menu");
    chk(menu_item, 32'h1, "skip item");
    esc(1);
    wr(pdv_pkg::ADDR_CTRL, 32'h0);
    $display("test menu done");
  endtask : t_menu

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    stop_test;
  end
  initial begin
    {hresetn, hsel, hwrite, key_esc, key_enter, key_up, key_down} = 7'h0;
    req = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    pval = 32'h0;
    pnt = 3'h0;
    dly = 4'h1;
    failures = 0;
    n_checks = 0;
    tick(2);
    hresetn <= 1'b1;
    t_ident;
    t_master;
    t_range;
    t_blink;
    t_menu;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
